// >>> dv/hfcw_far_model.sv
// dma and hdlc engine stand-ins on the transmit stream
`default_nettype none
module hfcw_far_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic dma_ready_i,
   input wire logic dma_fetch_i,
   output var hfcw_pkg::hfcw_word_t dma_data_o = '0,
   output logic dma_valid_o = 1'h0,
   output logic hdlc_ready_o = 1'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   import hfcw_pkg::*;
   // ==========================================
   // dma side
   // starts new words only while a refill runs but holds an untaken one past its end; idle data flips so stale values never match
   always @(posedge clk_i) begin
      if (rst_i) begin
         dma_valid_o <= 1'h0;
      end else if (!dma_valid_o || dma_ready_i) begin
         if (run_i && dma_fetch_i && ($urandom % 4) != 0) begin
            dma_valid_o <= 1'h1;
            // occasional frame ends so an early end can release the reader
            dma_data_o <= {1'(($urandom % 16) == 0), 32'($urandom)};
         end else begin
            dma_valid_o <= 1'h0;
            dma_data_o <= ~dma_data_o;
         end
      end
   end
   // ==========================================
   // hdlc side
   // random stalls so the two-entry buffer fills and drains
   always @(posedge clk_i) begin
      if (rst_i) begin
         hdlc_ready_o <= 1'h0;
      end else begin
         hdlc_ready_o <= ($urandom % 3) != 0;
      end
   end
endmodule // hfcw_far_model
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench of the fifo chain block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import hfcw_pkg::*;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic wb_cyc = 1'h0;
   logic wb_stb = 1'h0;
   logic wb_we = 1'h0;
   logic [15:0] wb_adr = '0;
   logic [3:0] wb_sel = 4'hf;
   logic [31:0] wb_wdat = '0;
   logic [31:0] wb_rdat;
   logic wb_ack;
   hfcw_word_t dma_data;
   hfcw_word_t hdlc_data;
   logic dma_valid, dma_ready, dma_fetch, hdlc_valid, hdlc_ready, hdlc_hold;
   logic rx_adv = 1'h0;
   logic [7:0] rx_ch = '0;
   logic [9:0] rx_blk;
   logic run = 1'h0;
   logic chk_rd = 1'h0;
   logic fetch_d = 1'h0;
   logic eof_seen = 1'h0;
   logic [31:0] rd;
   int errors = 0;
   int check_count = 0;
   int pushed = 0;
   int popped = 0;
   hfcw_word_t exp_q[$];
   logic [31:0] rd_q[$];

   always #5 clk_i = ~clk_i;

   hfcw_top #(.TX_MAX_BLOCKS(16)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .dma_data_i(dma_data),
      .dma_valid_i(dma_valid), .dma_ready_o(dma_ready), .dma_fetch_o(dma_fetch),
      .hdlc_data_o(hdlc_data), .hdlc_valid_o(hdlc_valid), .hdlc_ready_i(hdlc_ready),
      .hdlc_hold_o(hdlc_hold), .rx_adv_i(rx_adv), .rx_adv_chan_i(rx_ch), .rx_cur_blk_o(rx_blk));

   hfcw_far_model far (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .dma_ready_i(dma_ready),
      .dma_fetch_i(dma_fetch), .dma_data_o(dma_data), .dma_valid_o(dma_valid),
      .hdlc_ready_o(hdlc_ready));

   // ==========================================
   // checking and closing
   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      if (errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================
   // classic wishbone master; ack sampled high at a rising edge, then released
   task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic c, input logic [31:0] e);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc <= 1'h1;
      wb_stb <= 1'h1;
      wb_we <= w;
      wb_adr <= a;
      wb_wdat <= d;
      chk_rd <= c;
      if (c) rd_q.push_back(e);
      do begin
         @(posedge clk_i);
         n++;
         if (n > 50) begin
            errors++;
            final_report();
         end
      end while (wb_ack !== 1'h1);
      // read data taken at the same rising edge that shows ack, then released
      rd = wb_rdat;
      wb_cyc <= 1'h0;
      wb_stb <= 1'h0;
      chk_rd <= 1'h0;
   endtask

   // start an indirect access and wait for busy to clear before anything else
   task automatic ia(input logic [15:0] sel, input logic [15:0] v);
      int n;
      n = 0;
      wb(1'h1, sel, {16'h0, v}, 1'h0, '0);
      do begin
         wb(1'h0, sel, '0, 1'h0, '0);
         n++;
      end while (rd[15] !== 1'h0 && n < 30);
      check("busy", 33'(rd[15]), 33'h0);
      if (rd[15] !== 1'h0) final_report();
   endtask

   // ==========================================
   // watchers: note each dma word, compare each taken word and each noted read
   always @(negedge clk_i) begin
      fetch_d <= dma_fetch;
      // counts here hold only words moved at earlier edges, so they match the chain
      if (!rst_i && popped == 0)
         check("hold", 33'(hdlc_hold), 33'(pushed <= 12 && !eof_seen));
      if (dma_fetch === 1'h1 && !fetch_d && popped > 0)
         check("refill start", 33'(pushed - popped <= 14), 33'h1);
      if (dma_fetch === 1'h0 && fetch_d === 1'h1)
         check("refill end", 33'(pushed - popped >= 22), 33'h1);
      if (dma_valid && dma_ready === 1'h1) begin
         exp_q.push_back(dma_data);
         pushed++;
         if (dma_data.eof) eof_seen = 1'h1;
      end
      if (hdlc_valid === 1'h1 && hdlc_ready) begin
         if (popped == 0) check("first take", 33'(pushed > 12 || eof_seen), 33'h1);
         check("word", hdlc_data, exp_q.pop_front());
         popped++;
      end
      if (wb_ack === 1'h1 && chk_rd) check("read", 33'(wb_rdat), 33'(rd_q.pop_front()));
   end

   // ==========================================
   // main sequence
   initial begin
      logic [7:0] ch;
      logic [9:0] blk, nxt;
      int n;
      void'($urandom(32'hf1f885c6));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      wb(1'h0, SP_SEL_ADDR, '0, 1'h1, '0);
      wb(1'h0, LK_SEL_ADDR, '0, 1'h1, '0);
      wb(1'h1, 16'h0a00, 32'hffff_ffff, 1'h0, '0);
      wb(1'h0, 16'h0a00, '0, 1'h1, '0);
      // first and last channel plus one random; data cleared before read back
      for (int i = 0; i < 3; i++) begin
         ch = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         blk = (i == 1) ? 10'h3ff : 10'($urandom);
         wb(1'h1, SP_DATA_ADDR, {22'h0, blk}, 1'h0, '0);
         ia(SP_SEL_ADDR, {8'h00, ch});
         wb(1'h1, SP_DATA_ADDR, '0, 1'h0, '0);
         ia(SP_SEL_ADDR, {8'h40, ch});
         wb(1'h0, SP_DATA_ADDR, '0, 1'h1, {22'h0, blk});
      end
      // link the last block onward, then let the receiver advance
      nxt = blk ^ 10'h001;
      wb(1'h1, LK_DATA_ADDR, {22'h0, nxt}, 1'h0, '0);
      ia(LK_SEL_ADDR, {6'h00, blk});
      wb(1'h1, LK_DATA_ADDR, '0, 1'h0, '0);
      ia(LK_SEL_ADDR, {6'h10, blk});
      wb(1'h0, LK_DATA_ADDR, '0, 1'h1, {22'h0, nxt});
      @(posedge clk_i);
      rx_ch <= ch;
      rx_adv <= 1'h1;
      @(posedge clk_i);
      rx_adv <= 1'h0;
      repeat (2) @(negedge clk_i);
      check("current block", 33'(rx_blk), 33'(nxt));
      ia(SP_SEL_ADDR, {8'h40, ch});
      wb(1'h0, SP_DATA_ADDR, '0, 1'h1, {22'h0, nxt});
      // six-block chain, watermark three, then stream with stalls
      wb(1'h1, TX_CFG_ADDR, 32'h0003_0006, 1'h0, '0);
      run <= 1'h1;
      repeat (3000) @(posedge clk_i);
      run <= 1'h0;
      n = 0;
      while (popped != pushed && n < 500) begin
         @(posedge clk_i);
         n++;
      end
      check("drained", 33'(popped), 33'(pushed));
      final_report();
   end
endmodule // testbench
`default_nettype wire

// >>> src/hfcw_pkg.sv
// shared constants and types of the hdlc fifo chain watermark block
`default_nettype none
package hfcw_pkg;
   // ==========================================================
   // register byte addresses
   localparam logic [15:0] SP_SEL_ADDR = 16'h0900;
   localparam logic [15:0] SP_DATA_ADDR = 16'h0904;
   localparam logic [15:0] LK_SEL_ADDR = 16'h0910;
   localparam logic [15:0] LK_DATA_ADDR = 16'h0914;
   localparam logic [15:0] TX_CFG_ADDR = 16'h0980;
   localparam logic [15:0] TX_STAT_ADDR = 16'h0984;
   // ==========================================================
   // select and pointer field layout
   localparam int unsigned CHAN_W = 8;
   localparam int unsigned BLK_W = 10;
   localparam int unsigned RNW_BIT = 14;
   localparam int unsigned BUSY_BIT = 15;
   localparam int unsigned NUM_CHAN = 256;
   localparam int unsigned NUM_BLK = 1024;
   // ==========================================================
   // transmit config and status layout, reset values
   localparam int unsigned TXC_LEN_LSB = 0;
   localparam int unsigned TXC_WM_LSB = 16;
   localparam int unsigned TXS_CNT_LSB = 0;
   localparam int unsigned TXS_REFILL_BIT = 16;
   localparam int unsigned TXS_HOLD_BIT = 17;
   localparam logic [9:0] TXC_LEN_RST = 10'h004;
   localparam logic [9:0] TXC_WM_RST = 10'h001;
   localparam int unsigned WORDS_PER_BLK = 4;
   localparam int unsigned CNT_W = 12;
   // ==========================================================
   // indirect access latency in clock cycles
   localparam int unsigned IA_LAT = 2;
   localparam logic [1:0] IA_LAST = 2'h1;
   // ==========================================================
   // types
   typedef struct packed {
      logic eof;
      logic [31:0] data;
   } hfcw_word_t;
   typedef enum logic [2:0] {
      IA_IDLE = 3'b001,
      IA_SP = 3'b010,
      IA_LK = 3'b100
   } hfcw_ia_state_t;
endpackage
`default_nettype wire

// >>> src/hfcw_skid.sv
// two-entry buffer between the transmit chain and the hdlc engine
`default_nettype none
module hfcw_skid #(
   parameter int unsigned W = 33
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   logic [W-1:0] tail_r;
   logic tail_v_r;
   logic push, pop;
   assign push = in_valid_i & ~tail_v_r;
   assign pop = out_valid_o & out_ready_i;
   assign in_ready_o = ~tail_v_r;
   // ==========================================================
   // head is the output register, tail catches a word during a stall
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_valid_o <= 1'b0;
         tail_v_r <= 1'b0;
         out_data_o <= '0;
         tail_r <= '0;
      end else if (pop) begin
         if (tail_v_r) begin
            out_data_o <= tail_r;
            tail_v_r <= 1'b0;
         end else if (push) begin
            out_data_o <= in_data_i;
         end else begin
            out_valid_o <= 1'b0;
         end
      end else if (push) begin
         if (!out_valid_o) begin
            out_data_o <= in_data_i;
            out_valid_o <= 1'b1;
         end else begin
            tail_r <= in_data_i;
            tail_v_r <= 1'b1;
         end
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   stall_keeps_word_a: assert property (out_valid_o && !out_ready_i |=>
      out_valid_o && $stable(out_data_o)) else $error("stalled word changed");
endmodule // hfcw_skid
`default_nettype wire

// >>> src/hfcw_top.sv
// top of the hdlc fifo chain block: register slave, transmit chain, rx pointer access
//
// Design decision made here: register access over Wishbone.
`default_nettype none
// What this block does
// R1 - dma fetch begins only when the chain has drained to the low watermark
// R2 - once begun, fetching continues until the chain is full, ignoring frame ends
// R3 - no new fetch until chain length minus watermark blocks were consumed
// R4 - software keeps the low watermark between one and chain length minus two
// R5 - reader waits on an empty chain until past the watermark or end of frame
// R6 - channel index field holds channel number minus one
// R7 - select write with read bit clear copies data register into channel entry
// R8 - busy bit reads one during an indirect access, clears when it completes
// R9 - ten-bit start pointer picks any of 1024 blocks of the chain
// R10 - reading the start pointer returns the block now being written
// R11 - blocks of four words form per-channel circular chains of four or more
// R12 - software never links a block to itself
// R13 - select write with read bit set fetches the link entry; valid when not busy
// R14 - software waits for busy to clear before the next access
module hfcw_top #(
   parameter int unsigned TX_MAX_BLOCKS = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire hfcw_pkg::hfcw_word_t dma_data_i,
   input wire logic dma_valid_i,
   output logic dma_ready_o,
   output logic dma_fetch_o,
   output var hfcw_pkg::hfcw_word_t hdlc_data_o,
   output logic hdlc_valid_o,
   input wire logic hdlc_ready_i,
   output logic hdlc_hold_o,
   input wire logic rx_adv_i,
   input wire logic [hfcw_pkg::CHAN_W-1:0] rx_adv_chan_i,
   output logic [hfcw_pkg::BLK_W-1:0] rx_cur_blk_o
);
   import hfcw_pkg::*;
   localparam int unsigned TX_WORDS = TX_MAX_BLOCKS * WORDS_PER_BLK;
   localparam int unsigned AW = $clog2(TX_WORDS);

   // ==========================================================
   // bus slave
   logic ack_r;
   logic [31:0] rdat_r;
   logic [31:0] rd_mux;
   logic req, wr_req;
   logic wr_sp_sel, wr_sp_data, wr_lk_sel, wr_lk_data, wr_cfg;
   logic full16;

   // ==========================================================
   // indirect access state
   hfcw_ia_state_t ia_state_r;
   logic [1:0] ia_cnt_r;
   logic ia_last;
   logic [CHAN_W-1:0] sp_chan_r;
   logic sp_rnw_r;
   logic [BLK_W-1:0] lk_blk_r;
   logic lk_rnw_r;
   logic [BLK_W-1:0] sp_data_r;
   logic [BLK_W-1:0] lk_data_r;
   logic sp_busy, lk_busy;
   logic sp_done, lk_done;
   logic [BLK_W-1:0] sp_mem [NUM_CHAN];
   logic [BLK_W-1:0] lk_mem [NUM_BLK];
   logic [BLK_W-1:0] sp_rd_val;
   logic [BLK_W-1:0] lk_rd_val;
   logic [BLK_W-1:0] rx_cur_val;
   logic [BLK_W-1:0] rx_next_blk;
   logic [BLK_W-1:0] rx_cur_blk_r;

   // ==========================================================
   // transmit chain state
   logic [9:0] cfg_len_r;
   logic [9:0] cfg_wm_r;
   hfcw_word_t tx_mem [TX_WORDS];
   logic [CNT_W-1:0] wr_ptr_r, rd_ptr_r, cnt_r, eof_cnt_r;
   logic [CNT_W-1:0] cnt_nxt, eof_cnt_nxt;
   logic [CNT_W-1:0] cap_words, low_words;
   logic dma_ready_r;
   logic dma_push, mem_pop;
   hfcw_word_t pop_word;
   logic buf_in_ready;
   logic refill_nxt, refill, hold;

   // ==========================================================
   // address decode; writes take effect once, in the request cycle before ack rises
   assign req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr_req = req & wb_we_i;
   assign full16 = wb_sel_i[1:0] == 2'b11;
   assign wr_sp_sel = wr_req && wb_adr_i == SP_SEL_ADDR && full16;
   assign wr_sp_data = wr_req && wb_adr_i == SP_DATA_ADDR;
   assign wr_lk_sel = wr_req && wb_adr_i == LK_SEL_ADDR && full16;
   assign wr_lk_data = wr_req && wb_adr_i == LK_DATA_ADDR;
   assign wr_cfg = wr_req && wb_adr_i == TX_CFG_ADDR && wb_sel_i == 4'hf;

   // read mux; unmapped addresses answer zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (wb_adr_i)
         SP_SEL_ADDR: begin
            rd_mux[CHAN_W-1:0] = sp_chan_r; // see R6
            rd_mux[RNW_BIT] = sp_rnw_r;
            rd_mux[BUSY_BIT] = sp_busy; // see R8
         end
         SP_DATA_ADDR: rd_mux[BLK_W-1:0] = sp_data_r;
         LK_SEL_ADDR: begin
            rd_mux[BLK_W-1:0] = lk_blk_r;
            rd_mux[RNW_BIT] = lk_rnw_r;
            rd_mux[BUSY_BIT] = lk_busy; // see R8
         end
         LK_DATA_ADDR: rd_mux[BLK_W-1:0] = lk_data_r;
         TX_CFG_ADDR: begin
            rd_mux[TXC_LEN_LSB +: 10] = cfg_len_r;
            rd_mux[TXC_WM_LSB +: 10] = cfg_wm_r;
         end
         TX_STAT_ADDR: begin
            rd_mux[TXS_CNT_LSB +: CNT_W] = cnt_r;
            rd_mux[TXS_REFILL_BIT] = refill;
            rd_mux[TXS_HOLD_BIT] = hold;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // one-cycle answer, dropped the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else begin
         ack_r <= req;
         if (req) begin
            rdat_r <= rd_mux;
         end
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // ==========================================================
   // indirect access sequencer; one engine serves both select registers
   assign ia_last = ia_cnt_r == IA_LAST;
   assign sp_busy = ia_state_r == IA_SP;
   assign lk_busy = ia_state_r == IA_LK;
   assign sp_done = sp_busy & ia_last;
   assign lk_done = lk_busy & ia_last;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ia_state_r <= IA_IDLE;
         ia_cnt_r <= 2'h0;
         sp_chan_r <= '0;
         sp_rnw_r <= 1'b0;
         lk_blk_r <= '0;
         lk_rnw_r <= 1'b0;
      end else begin
         unique case (ia_state_r)
            IA_IDLE: begin
               ia_cnt_r <= 2'h0;
               // a select written while busy is dropped, software must poll first
               if (wr_sp_sel) begin
                  sp_chan_r <= wb_dat_i[CHAN_W-1:0]; // see R6
                  sp_rnw_r <= wb_dat_i[RNW_BIT];
                  ia_state_r <= IA_SP; // see R8
               end else if (wr_lk_sel) begin
                  lk_blk_r <= wb_dat_i[BLK_W-1:0];
                  lk_rnw_r <= wb_dat_i[RNW_BIT]; // see R13
                  ia_state_r <= IA_LK; // see R8
               end
            end
            IA_SP, IA_LK: begin
               ia_cnt_r <= ia_cnt_r + 2'h1;
               if (ia_last) begin
                  ia_state_r <= IA_IDLE; // see R8
               end
            end
            default: ia_state_r <= IA_IDLE;
         endcase
      end
   end

   // ==========================================================
   // pointer storage; entry 0 of the start table is the first channel
   assign sp_rd_val = sp_mem[sp_chan_r];
   assign lk_rd_val = lk_mem[lk_blk_r];
   assign rx_cur_val = sp_mem[rx_adv_chan_i];
   assign rx_next_blk = lk_mem[rx_cur_val];

   // rx advance walks the chain; a host write in the same cycle wins
   always_ff @(posedge clk_i) begin
      if (rx_adv_i) begin
         sp_mem[rx_adv_chan_i] <= rx_next_blk; // see R10
      end
      if (sp_done && !sp_rnw_r) begin
         sp_mem[sp_chan_r] <= sp_data_r; // see R7
      end
      if (lk_done && !lk_rnw_r) begin
         lk_mem[lk_blk_r] <= lk_data_r; // see R11
      end
   end

   // data registers, byte lane by byte lane, loaded by read completions
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sp_data_r <= '0;
         lk_data_r <= '0;
      end else begin
         if (sp_done && sp_rnw_r) begin
            sp_data_r <= sp_rd_val; // see R10
         end else if (wr_sp_data) begin
            if (wb_sel_i[0]) sp_data_r[7:0] <= wb_dat_i[7:0]; // see R9
            if (wb_sel_i[1]) sp_data_r[9:8] <= wb_dat_i[9:8];
         end
         if (lk_done && lk_rnw_r) begin
            lk_data_r <= lk_rd_val; // see R13
         end else if (wr_lk_data) begin
            if (wb_sel_i[0]) lk_data_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) lk_data_r[9:8] <= wb_dat_i[9:8];
         end
      end
   end

   // block now being written, reported after each rx advance
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_cur_blk_r <= '0;
      end else if (rx_adv_i) begin
         rx_cur_blk_r <= rx_next_blk;
      end
   end
   assign rx_cur_blk_o = rx_cur_blk_r;

   // ==========================================================
   // transmit configuration; a write also flushes the chain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_len_r <= TXC_LEN_RST;
         cfg_wm_r <= TXC_WM_RST;
      end else if (wr_cfg) begin
         cfg_len_r <= wb_dat_i[TXC_LEN_LSB +: 10];
         cfg_wm_r <= wb_dat_i[TXC_WM_LSB +: 10]; // see R4
      end
   end
   // counts in words, so chain length and watermark are scaled by four words per block
   assign cap_words = {cfg_len_r, 2'b00};
   assign low_words = {cfg_wm_r, 2'b00};

   // ==========================================================
   // transmit chain storage
   assign dma_push = dma_valid_i & dma_ready_r;
   assign mem_pop = (cnt_r != '0) & ~hold & buf_in_ready; // see R5
   assign pop_word = tx_mem[rd_ptr_r[AW-1:0]];

   always_comb begin
      if (wr_cfg) begin
         cnt_nxt = '0;
         eof_cnt_nxt = '0;
      end else begin
         cnt_nxt = CNT_W'(cnt_r + {{(CNT_W-1){1'b0}}, dma_push}
                   - {{(CNT_W-1){1'b0}}, mem_pop});
         eof_cnt_nxt = CNT_W'(eof_cnt_r + {{(CNT_W-1){1'b0}}, dma_push & dma_data_i.eof}
                       - {{(CNT_W-1){1'b0}}, mem_pop & pop_word.eof});
      end
   end

   always_ff @(posedge clk_i) begin
      if (dma_push) begin
         tx_mem[wr_ptr_r[AW-1:0]] <= dma_data_i;
      end
   end

   // circular pointers wrap at the programmed chain length
   always_ff @(posedge clk_i) begin
      if (rst_i || wr_cfg) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
         eof_cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
         eof_cnt_r <= eof_cnt_nxt;
         if (dma_push) begin
            wr_ptr_r <= (wr_ptr_r == cap_words - 1'b1) ? '0 : wr_ptr_r + 1'b1; // see R11
         end
         if (mem_pop) begin
            rd_ptr_r <= (rd_ptr_r == cap_words - 1'b1) ? '0 : rd_ptr_r + 1'b1;
         end
      end
   end

   // ready is registered, so it looks at the next count to avoid overfill
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dma_ready_r <= 1'b0;
      end else begin
         dma_ready_r <= refill_nxt && (cnt_nxt < cap_words) && !wr_cfg; // see R2
      end
   end
   assign dma_ready_o = dma_ready_r;
   assign dma_fetch_o = refill; // see R1
   assign hdlc_hold_o = hold;

   hfcw_tx_wm u_wm (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .words_nxt_i(cnt_nxt),
      .cap_words_i(cap_words),
      .low_words_i(low_words),
      .eof_any_nxt_i(eof_cnt_nxt != '0),
      .refill_nxt_o(refill_nxt),
      .refill_o(refill),
      .hold_o(hold)
   );

   hfcw_skid #(.W($bits(hfcw_word_t))) u_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_data_i(pop_word),
      .in_valid_i(mem_pop),
      .in_ready_o(buf_in_ready),
      .out_data_o(hdlc_data_o),
      .out_valid_o(hdlc_valid_o),
      .out_ready_i(hdlc_ready_i)
   );

   // ==========================================================
   // checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence sp_busy_run;
      sp_busy [*2] ##1 !sp_busy;
   endsequence
   sequence lk_busy_run;
      lk_busy [*2] ##1 !lk_busy;
   endsequence

   start_busy_run_a: assert property ($rose(sp_busy) |-> sp_busy_run) // see R8
      else $error("start pointer busy length wrong");
   link_busy_run_a: assert property ($rose(lk_busy) |-> lk_busy_run) // see R8
      else $error("link busy length wrong");
   start_write_copy_a: assert property (sp_done && !sp_rnw_r && !rx_adv_i |=> // see R7
      sp_rd_val == $past(sp_data_r)) else $error("start pointer not stored");
   start_read_live_a: assert property (sp_done && sp_rnw_r |=> // see R10
      sp_data_r == $past(sp_rd_val)) else $error("start pointer read stale");
   link_read_data_a: assert property (lk_done && lk_rnw_r |=> // see R13
      !lk_busy && lk_data_r == $past(lk_rd_val)) else $error("link read data wrong");
   rx_walk_chain_a: assert property (rx_adv_i |=> // see R9
      rx_cur_blk_o == $past(rx_next_blk)) else $error("rx pointer did not follow link");
   fetch_needs_refill_a: assert property (dma_ready_o |-> refill) // see R1
      else $error("dma accepted outside refill");
   chain_no_overfill_a: assert property (cnt_r <= cap_words) // see R2
      else $error("chain overfilled");
   select_field_a: assert property (wr_sp_sel && !sp_busy && !lk_busy |=> // see R6
      sp_chan_r == $past(wb_dat_i[CHAN_W-1:0])) else $error("channel index not taken");
endmodule // hfcw_top
`default_nettype wire

// >>> src/hfcw_tx_wm.sv
// transmit low-watermark refill and read hold-off control
`default_nettype none
module hfcw_tx_wm (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [hfcw_pkg::CNT_W-1:0] words_nxt_i,
   input wire logic [hfcw_pkg::CNT_W-1:0] cap_words_i,
   input wire logic [hfcw_pkg::CNT_W-1:0] low_words_i,
   input wire logic eof_any_nxt_i,
   output logic refill_nxt_o,
   output logic refill_o,
   output logic hold_o
);
   import hfcw_pkg::*;
   logic hold_nxt;
   // ==========================================================
   // refill starts at the watermark and runs until the chain is full
   always_comb begin
      if (refill_o) begin
         refill_nxt_o = words_nxt_i < cap_words_i; // see R2
      end else begin
         // the gap above the mark must drain before the next fetch
         refill_nxt_o = (words_nxt_i <= low_words_i) && (words_nxt_i < cap_words_i); // see R1
      end
   end
   // empty chain holds the reader off until past the mark or an end of frame
   always_comb begin
      hold_nxt = hold_o;
      if (words_nxt_i == '0) begin
         hold_nxt = 1'b1;
      end else if (words_nxt_i > low_words_i || eof_any_nxt_i ||
                   words_nxt_i == cap_words_i) begin
         hold_nxt = 1'b0; // see R5
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refill_o <= 1'b0;
         hold_o <= 1'b1;
      end else begin
         refill_o <= refill_nxt_o; // see R3
         hold_o <= hold_nxt;
      end
   end
   // ==========================================================
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   refill_start_a: assert property ( // see R1
      !refill_o && words_nxt_i <= low_words_i && words_nxt_i < cap_words_i |=> refill_o)
      else $error("refill did not start at watermark");
   refill_fill_a: assert property ( // see R2
      refill_o && words_nxt_i < cap_words_i |=> refill_o)
      else $error("refill stopped before chain full");
   no_early_fetch_a: assert property ( // see R3
      !refill_o && words_nxt_i > low_words_i |=> !refill_o)
      else $error("fetch restarted above watermark");
   hold_release_a: assert property ( // see R5
      hold_o && words_nxt_i > low_words_i |=> !hold_o)
      else $error("reader still held above watermark");
endmodule // hfcw_tx_wm
`default_nettype wire
